// [logic/rheostat_defines.vh]
// Constants shared by the dual rheostat serial command logic
`ifndef RHEOSTAT_DEFINES_VH
`define RHEOSTAT_DEFINES_VH

// ==========================================================
// Frame layout
`define FRAME_BITS      5'h18
`define FRAME_CNT_MAX   5'h1F
`define CMD_MSB         23
`define CMD_LSB         20
`define ADDR_MSB        19
`define ADDR_LSB        16
`define DATA_MSB        15
`define DATA_LSB        0

// ==========================================================
// Command codes
`define CMD_NOP         4'h0
`define CMD_RESTORE     4'h1
`define CMD_SAVE        4'h2
`define CMD_STORE_USER  4'h3
`define CMD_RESTORE_ALL 4'h8
`define CMD_READ_NV     4'h9
`define CMD_READ_WIPER  4'hA
`define CMD_WRITE       4'hB
`define CMD_DOUBLE      4'hC
`define CMD_DOUBLE_ALL  4'hD
`define CMD_INCREMENT   4'hE

// ==========================================================
// Wiper and nonvolatile memory
`define WIPER_MAX       10'h3FF
`define WIPER_RST       10'h000
`define NV_DEFAULT      16'h0200
`define USER_FIRST      4'h2
`define USER_LAST       4'hE
`define TX_RST          24'h000000
// Synchroniser idle levels, order {preset_n, wp_n, sdi, cs_n, sclk}
`define SYNC_RST        5'h1A

`endif

// [logic/spi_frame_shifter.v]
// Serial slave shifter for 24-bit frames, SPI modes 0 and 3
`timescale 1ns/1ps
`include "rheostat_defines.vh"

module spi_frame_shifter (
    input  wire        core_clk_i,
    input  wire        nrst_i,
    input  wire        sclk_s_i,
    input  wire        cs_n_s_i,
    input  wire        sdi_s_i,
    input  wire [23:0] load_word_i,
    output reg         frame_valid_o,
    output reg  [23:0] frame_word_o,
    output wire        sdo_o,
    output reg         sdo_oe_o
);

    reg        sclk_prev_q;
    reg        cs_prev_q;
    reg        rose_q;
    reg  [4:0] cnt_q;
    reg [23:0] rx_q;
    reg [23:0] tx_q;

    wire sclk_rise = sclk_s_i & ~sclk_prev_q;
    wire sclk_fall = ~sclk_s_i & sclk_prev_q;
    wire cs_fall   = ~cs_n_s_i & cs_prev_q;
    wire cs_rise   = cs_n_s_i & ~cs_prev_q;

    assign sdo_o = tx_q[23];

    // ==========================================================
    // Shift engine
    // Both modes sample on the rising edge and change data on the falling edge.
    // In mode 3 the first falling edge precedes any rising edge, so it is skipped.
    always @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            sclk_prev_q   <= 1'b0;
            cs_prev_q     <= 1'b1;
            rose_q        <= 1'b0;
            cnt_q         <= 5'h00;
            rx_q          <= 24'h000000;
            tx_q          <= `TX_RST;
            frame_valid_o <= 1'b0;
            frame_word_o  <= 24'h000000;
            sdo_oe_o      <= 1'b0;
        end
        else
        begin
            sclk_prev_q   <= sclk_s_i;
            cs_prev_q     <= cs_n_s_i;
            frame_valid_o <= 1'b0;
            sdo_oe_o      <= ~cs_n_s_i;
            if (cs_fall)
            begin
                tx_q   <= load_word_i;
                cnt_q  <= 5'h00;
                rose_q <= 1'b0;
            end
            else if (!cs_n_s_i)
            begin
                if (sclk_rise)
                begin
                    rx_q   <= {rx_q[22:0], sdi_s_i};
                    rose_q <= 1'b1;
                    // Count on past a frame and stop there, so long frames never look like 24
                    if (cnt_q != `FRAME_CNT_MAX)
                        cnt_q <= cnt_q + 5'h01;
                end
                if (sclk_fall && rose_q)
                    tx_q <= {tx_q[22:0], 1'b0};
            end
            // Frames of the wrong length are dropped whole
            if (cs_rise && cnt_q == `FRAME_BITS)
            begin
                frame_valid_o <= 1'b1;
                frame_word_o  <= rx_q;
            end
        end
    end

endmodule

// [logic/dual_rheostat_serial_commands.v]
// Command interpreter of a dual rheostat with nonvolatile wiper storage
// How it works
// - Command B, address 0 or 1, loads frame data into that wiper setting.
// - Command E adds one to the addressed channel's wiper setting.
// - Command 2 saves the addressed wiper setting into its nonvolatile location.
// - Write-protect low blocks every nonvolatile memory write.
// - Command 1 reloads the addressed wiper setting from nonvolatile memory.
// - Command 8 reloads both wiper settings from nonvolatile memory.
// - Power-on and preset strobe restore both wipers from nonvolatile memory.
// - Command C doubles the addressed wiper setting by a left shift.
// - All-channel shift command doubles both wiper settings in one frame.
// - Command 3 stores data into user word at address 2 to 14.
// - Command 9 fetches a nonvolatile word, output during the next frame.
// - Command A prepares wiper readback in the next frame's low bits.
// - Serial port works in SPI modes 0 and 3.
// - Each wiper setting is a 10-bit code, 1024 positions.
`timescale 1ns/1ps
`include "rheostat_defines.vh"

module dual_rheostat_serial_commands (
    input  wire       core_clk_i,
    input  wire       nrst_i,
    input  wire       spi_sclk_i,
    input  wire       spi_cs_n_i,
    input  wire       spi_sdi_i,
    input  wire       wp_n_i,
    input  wire       preset_strobe_n_i,
    output wire       spi_sdo_o,
    output wire       spi_sdo_oe_o,
    output wire [9:0] wiper_one_o,
    output wire [9:0] wiper_two_o
);

    // ==========================================================
    // Input synchronisers
    // The link clock is only sampled, so each of its phases must last three cycles.
    // Two stages keep a pin edge near the clock edge away from the decode logic.
    reg  [4:0] meta_q;
    reg  [4:0] sync_q;
    reg        preset_prev_q;
    reg        por_q;

    wire sclk_s   = sync_q[0];
    wire cs_n_s   = sync_q[1];
    wire sdi_s    = sync_q[2];
    wire wp_n_s   = sync_q[3];
    wire preset_s = sync_q[4];

    always @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            meta_q <= `SYNC_RST;
            sync_q <= `SYNC_RST;
        end
        else
        begin
            meta_q <= {preset_strobe_n_i, wp_n_i, spi_sdi_i, spi_cs_n_i, spi_sclk_i};
            sync_q <= meta_q;
        end
    end

    // ==========================================================
    // Frame shifter
    wire        frame_valid;
    wire [23:0] frame_word;
    reg  [23:0] tx_word_q;

    spi_frame_shifter u_shifter (
        .core_clk_i    (core_clk_i),
        .nrst_i        (nrst_i),
        .sclk_s_i      (sclk_s),
        .cs_n_s_i      (cs_n_s),
        .sdi_s_i       (sdi_s),
        .load_word_i   (tx_word_q),
        .frame_valid_o (frame_valid),
        .frame_word_o  (frame_word),
        .sdo_o         (spi_sdo_o),
        .sdo_oe_o      (spi_sdo_oe_o)
    );

    // ==========================================================
    // Frame decode
    wire  [3:0] cmd  = frame_word[`CMD_MSB:`CMD_LSB];
    wire  [3:0] addr = frame_word[`ADDR_MSB:`ADDR_LSB];
    wire [15:0] data = frame_word[`DATA_MSB:`DATA_LSB];
    // Unknown codes fall through every decode and are only echoed
    // Channel commands only answer to addresses 0 and 1
    wire        chan_ok = (addr[3:1] == 3'h0);

    function is_cmd;
        input [3:0] code;
        begin
            is_cmd = frame_valid && (cmd == code);
        end
    endfunction

    // Saturating increment, one step up but held at full scale
    function [9:0] sat_inc;
        input [9:0] w;
        begin
            sat_inc = (w == `WIPER_MAX) ? `WIPER_MAX : w + 10'h001;
        end
    endfunction

    // Saturating doubling, a set top bit would shift out, so clamp
    function [9:0] sat_dbl;
        input [9:0] w;
        begin
            sat_dbl = w[9] ? `WIPER_MAX : {w[8:0], 1'b0};
        end
    endfunction

    // ==========================================================
    // Nonvolatile memory
    // Addresses 0 and 1 hold the wiper copies, 2 to 14 the user words.
    // Contents survive nrst_i; only the power-up image gives their first value.
    // Writes land at once; the slow cell programming time is not modelled.
    reg  [15:0] nv_mem [0:15];
    integer     k;

    initial
    begin
        for (k = 0; k < 16; k = k + 1)
            nv_mem[k] = `NV_DEFAULT;
    end

    wire [9:0] wiper_sel;
    wire       save_hit  = is_cmd(`CMD_SAVE) && chan_ok;
    wire       store_hit = is_cmd(`CMD_STORE_USER) &&
                           (addr >= `USER_FIRST) && (addr <= `USER_LAST);
    wire       nv_we     = (save_hit || store_hit) && wp_n_s;
    wire [15:0] nv_wdata = save_hit ? {6'h00, wiper_sel} : data;

    always @(posedge core_clk_i)
    begin
        if (nrst_i && nv_we)
            nv_mem[addr] <= nv_wdata;
    end

    // ==========================================================
    // Restore sources
    // por_q is set by reset and lasts one cycle past the release.
    // A restore outranks any wiper command landing in the same cycle; a save or store still writes.
    wire preset_fall = ~preset_s & preset_prev_q;
    wire restore_all = por_q || preset_fall || is_cmd(`CMD_RESTORE_ALL);

    always @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            por_q         <= 1'b1;
            preset_prev_q <= 1'b1;
        end
        else
        begin
            por_q         <= 1'b0;
            preset_prev_q <= preset_s;
        end
    end

    // ==========================================================
    // Wiper setting registers, one per channel
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1)
        begin : chan
            reg  [9:0] w_q;
            wire       hit = frame_valid && chan_ok && (addr[0] == i);
            wire [9:0] nv_w = nv_mem[i][9:0];

            always @(posedge core_clk_i)
            begin
                if (!nrst_i)
                    w_q <= `WIPER_RST;
                else if (restore_all)
                    w_q <= nv_w;
                else if (is_cmd(`CMD_DOUBLE_ALL))
                    w_q <= sat_dbl(w_q);
                else if (hit)
                begin
                    // Data bits above the tenth are dropped on a write
                    case (cmd)
                        `CMD_WRITE:     w_q <= data[9:0];
                        `CMD_INCREMENT: w_q <= sat_inc(w_q);
                        `CMD_DOUBLE:    w_q <= sat_dbl(w_q);
                        `CMD_RESTORE:   w_q <= nv_w;
                        default:        w_q <= w_q;
                    endcase
                end
            end
        end
    endgenerate

    assign wiper_sel   = addr[0] ? chan[1].w_q : chan[0].w_q;
    assign wiper_one_o = chan[0].w_q;
    assign wiper_two_o = chan[1].w_q;

    // ==========================================================
    // Word for the next frame's serial output
    // Echo by default, so a daisy chain or a host can check what was received.
    // A refused channel read echoes too, so the host can see it was ignored.
    always @(posedge core_clk_i)
    begin
        if (!nrst_i)
            tx_word_q <= `TX_RST;
        else if (frame_valid)
        begin
            if (cmd == `CMD_READ_NV)
                tx_word_q <= {cmd, addr, nv_mem[addr]};
            else if (cmd == `CMD_READ_WIPER && chan_ok)
                tx_word_q <= {cmd, addr, 6'h00, wiper_sel};
            else
                tx_word_q <= frame_word;
        end
    end

endmodule

// [test/rheostat_sva.sv]
// Port checks for the dual rheostat serial command logic
`timescale 1ns/1ps
module rheostat_sva (
    input wire       core_clk_i,
    input wire       nrst_i,
    input wire       spi_sclk_i,
    input wire       spi_cs_n_i,
    input wire       spi_sdi_i,
    input wire       wp_n_i,
    input wire       preset_strobe_n_i,
    input wire       spi_sdo_o,
    input wire       spi_sdo_oe_o,
    input wire [9:0] wiper_one_o,
    input wire [9:0] wiper_two_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i);
    // ==========================================================
    // Quiet link
    // Eight cycles outlast the synchroniser and the command latency
    sequence link_quiet;
        ($stable(spi_cs_n_i) && preset_strobe_n_i)[*8];
    endsequence
    sequence sclk_quiet;
        ($stable(spi_sclk_i) && $stable(spi_cs_n_i))[*8];
    endsequence
    sequence in_frame;
        (!spi_cs_n_i && preset_strobe_n_i)[*6];
    endsequence
    AST_W1_HOLDS: assert property (link_quiet |=> $stable(wiper_one_o))
        else $error("wiper one moved on a quiet link");
    AST_W2_HOLDS: assert property (link_quiet |=> $stable(wiper_two_o))
        else $error("wiper two moved on a quiet link");
    AST_NO_MOVE_IN_FRAME: assert property (in_frame |=> $stable({wiper_one_o, wiper_two_o}))
        else $error("wiper moved before the frame ended");
    AST_SDO_HOLDS: assert property (sclk_quiet |=> $stable(spi_sdo_o))
        else $error("serial output moved without a clock edge");
    AST_OE_ON: assert property ($fell(spi_cs_n_i) |-> ##[1:5] spi_sdo_oe_o)
        else $error("output enable late after select");
    AST_OE_OFF: assert property ($rose(spi_cs_n_i) |-> ##[1:5] !spi_sdo_oe_o)
        else $error("output enable late after deselect");
    AST_OE_SEL: assert property ((!spi_cs_n_i)[*6] |-> spi_sdo_oe_o)
        else $error("output enable low while selected");
    AST_OE_IDLE: assert property ((spi_cs_n_i)[*6] |-> !spi_sdo_oe_o)
        else $error("output enable high while deselected");
endmodule
bind dual_rheostat_serial_commands rheostat_sva i_rheostat_sva (
    .core_clk_i, .nrst_i, .spi_sclk_i, .spi_cs_n_i, .spi_sdi_i, .wp_n_i,
    .preset_strobe_n_i, .spi_sdo_o, .spi_sdo_oe_o, .wiper_one_o, .wiper_two_o);

// [test/spi_host_model.sv]
// Host side serial master sending 24-bit frames
`timescale 1ns/1ps
module spi_host_model (
    output logic sclk_o,
    output logic cs_n_o,
    output logic sdi_o,
    input  wire  sdo_i
);
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o  = 1'b0;
    end
    // ==========================================================
    // One frame, MSB first, 320 ns link clock, stands still between frames
    // nb bits of w are sent, so frames of the wrong length can be made too
    task automatic xfer(input logic [31:0] w, input int nb, input logic m3,
                        output logic [23:0] r);
        integer i;
        begin
            r = 24'h000000;
            sclk_o <= m3;
            #200 cs_n_o <= 1'b0;
            #200;
            for (i = nb - 1; i >= 0; i--)
            begin
                sclk_o <= 1'b0;
                sdi_o  <= w[i];
                #160 sclk_o <= 1'b1;
                #150 r = {r[22:0], sdo_i};
                #10;
            end
            sclk_o <= m3;
            #160 cs_n_o <= 1'b1;
            // A released line must not keep showing the last bit
            sdi_o <= ~w[0];
            #400;
        end
    endtask
endmodule

// [test/dual_rheostat_serial_commands_tb_top.sv]
// Self-checking bench for the dual rheostat serial command logic
`timescale 1ns/1ps
`include "rheostat_defines.vh"
module dual_rheostat_serial_commands_tb_top;
    localparam logic [15:0] NV = `NV_DEFAULT;
    logic        clk;
    logic        nrst;
    logic        wp_n;
    logic        pre_n;
    logic        m3;
    logic [23:0] rx;
    wire         sclk;
    wire         cs_n;
    wire         sdi;
    wire         sdo;
    wire  [9:0]  w1;
    wire  [9:0]  w2;
    integer      miscompares;
    integer      n_compared;
    dual_rheostat_serial_commands i_dual_rheostat_serial_commands (
        .core_clk_i(clk), .nrst_i(nrst), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
        .spi_sdi_i(sdi), .wp_n_i(wp_n), .preset_strobe_n_i(pre_n), .spi_sdo_o(sdo),
        .spi_sdo_oe_o(), .wiper_one_o(w1), .wiper_two_o(w2));
    spi_host_model i_spi_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ==========================================================
    // Helpers
    task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
        n_compared++;
        if (s !== e)
        begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic f(input logic [23:0] w);
        i_spi_host_model.xfer({8'h00, w}, 24, m3, rx);
    endtask
    task automatic ww(input logic [9:0] a, input logic [9:0] b);
        chk("wiper_one", {14'h0, w1}, {14'h0, a});
        chk("wiper_two", {14'h0, w2}, {14'h0, b});
    endtask
    task automatic pin(input logic wp, input logic pr);
        @(posedge clk);
        wp_n  <= wp;
        pre_n <= pr;
        repeat (8) @(posedge clk);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_cmds;
        m3 = 1'b0;
        ww(NV[9:0], NV[9:0]);
        f(24'hB00100);
        f(24'hB10200);
        chk("echo", rx, 24'hB00100);
        ww(10'h100, 10'h200);
        m3 = 1'b1;
        f(24'hE00000);
        chk("echo_m3", rx, 24'hB10200);
        ww(10'h101, 10'h200);
        f(24'hB003FF);
        f(24'hE00000);
        ww(10'h3FF, 10'h200);
        f(24'hB00200);
        f(24'hC00000);
        ww(10'h3FF, 10'h200);
        f(24'hB00081);
        f(24'hB10123);
        f(24'hD00000);
        ww(10'h102, 10'h246);
        f(24'hA00000);
        f(24'h000000);
        chk("wiper_read", rx, 24'hA00102);
        $display("test cmds done");
    endtask
    task automatic t_nv;
        m3 = 1'b0;
        f(24'hB00155);
        f(24'h200000);
        f(24'hB00000);
        f(24'h100000);
        f(24'h000000);
        ww(10'h155, 10'h246);
        pin(1'b0, 1'b1);
        f(24'hB00077);
        f(24'h200000);
        f(24'h32FFFF);
        pin(1'b1, 1'b1);
        f(24'hB10000);
        f(24'h800000);
        ww(10'h155, NV[9:0]);
        f(24'hB00000);
        pin(1'b1, 1'b0);
        pin(1'b1, 1'b1);
        ww(10'h155, NV[9:0]);
        $display("test nv done");
    endtask
    task automatic t_user;
        m3 = 1'b1;
        f(24'h92AAAA);
        f(24'h000000);
        chk("user_wp", rx, {8'h92, NV});
        f(24'h32AAAA);
        f(24'h335555);
        f(24'h920000);
        f(24'h000000);
        chk("spare_word_one", rx, 24'h92AAAA);
        f(24'h930000);
        f(24'h000000);
        chk("spare_word_two", rx, 24'h935555);
        f(24'h3F1234);
        f(24'h000000);
        chk("user_bad_addr", rx, 24'h3F1234);
        f(24'h9F0000);
        f(24'h000000);
        chk("user15", rx, {8'h9F, NV});
        $display("test user done");
    endtask
    // Frames of 25 and 23 bits and channel commands at bad addresses are refused
    task automatic t_len;
        m3 = 1'b0;
        f(24'hB00123);
        i_spi_host_model.xfer({7'h00, 24'hB003FF, 1'b1}, 25, m3, rx);
        i_spi_host_model.xfer({9'h000, 23'h5801FF}, 23, m3, rx);
        f(24'h000000);
        chk("bad_len_echo", rx, 24'hB00123);
        ww(10'h123, 10'h200);
        f(24'hB20300);
        f(24'hA20000);
        f(24'hB1FEDC);
        chk("bad_read_echo", rx, 24'hA20000);
        ww(10'h123, 10'h2DC);
        $display("test len done");
    endtask
    task automatic print_verdict;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        miscompares = 0;
        n_compared  = 0;
        nrst  = 1'b0;
        wp_n  = 1'b1;
        pre_n = 1'b1;
        m3    = 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        t_cmds;
        t_nv;
        t_user;
        t_len;
        print_verdict;
    end
    initial
    begin
        #2000000;
        miscompares++;
        print_verdict;
    end
endmodule
